// ==== rtl/msm_pkg.sv ====
// package for the mode select and memory map block
// assumes a 16-bit cpu address bus and 8-bit data
package msm_pkg;
   localparam logic [15:0] MSM_PRIO_MISC_ADDR = 16'h103C;
   localparam logic [15:0] MSM_REG_BASE = 16'h1000;
   localparam logic [15:0] MSM_REG_MASK = 16'hFFC0;
   localparam logic [15:0] MSM_RAM_BASE = 16'h0000;
   localparam logic [15:0] MSM_RAM_MASK = 16'hFE00;
   localparam logic [15:0] MSM_BOOT_BASE = 16'hBF00;
   localparam logic [15:0] MSM_BOOT_MASK = 16'hFF00;
   localparam logic [15:0] MSM_ROM_BASE = 16'hC000;
   localparam logic [15:0] MSM_ROM_MASK = 16'hC000;
   localparam logic [15:0] MSM_EE512_BASE = 16'hB600;
   localparam logic [15:0] MSM_EE512_MASK = 16'hFE00;
   localparam logic [11:0] MSM_EE2K_LOW = 12'h800;
   localparam logic [15:0] MSM_NORMAL_VEC = 16'hFFFA;
   localparam logic [15:0] MSM_SPECIAL_VEC = 16'hBFFA;
   localparam logic [3:0] MSM_WINDOW_RST = 4'hF;
   localparam int MSM_BOOT_BIT = 7;
   localparam int MSM_SPECIAL_BIT = 6;
   localparam int MSM_LATCH_A_BIT = 5;
   localparam int MSM_RVIS_BIT = 4;
   localparam logic [3:0] MSM_PSEL_RST = 4'h6;
   typedef enum logic [1:0] {
      MSM_SINGLE,
      MSM_EXPANDED,
      MSM_BOOTSTRAP,
      MSM_TEST
   } msm_mode_e;
   typedef enum logic [2:0] {
      MSM_SEL_NONE,
      MSM_SEL_REG,
      MSM_SEL_RAM,
      MSM_SEL_ROM,
      MSM_SEL_BOOT,
      MSM_SEL_EE
   } msm_sel_e;
endpackage

// ==== rtl/msm_decode.sv ====
// memory map decoder with fixed resource priority
// assumes enables come from the control register block
`timescale 1ns/1ps
`default_nettype none
module msm_decode
   import msm_pkg::*;
(
   input wire logic [15:0] i_addr,
   input wire logic i_boot_en,
   input wire logic i_rom_en,
   input wire logic i_ee_big,
   input wire logic i_ee_en,
   input wire logic [3:0] i_window,
   output msm_sel_e o_sel
);
   wire hit_reg = (i_addr & MSM_REG_MASK) == MSM_REG_BASE;
   wire hit_ram = (i_addr & MSM_RAM_MASK) == MSM_RAM_BASE;
   wire hit_boot = i_boot_en && ((i_addr & MSM_BOOT_MASK) == MSM_BOOT_BASE);
   wire hit_rom = i_rom_en && ((i_addr & MSM_ROM_MASK) == MSM_ROM_BASE);
   wire hit_ee_small = (i_addr & MSM_EE512_MASK) == MSM_EE512_BASE;
   wire hit_ee_big = (i_addr[15:12] == i_window) && (i_addr[11] == MSM_EE2K_LOW[11]);
   wire hit_ee = i_ee_en && (i_ee_big ? hit_ee_big : hit_ee_small);
   // registers, then ram, then rom class memories
   assign o_sel = hit_reg ? MSM_SEL_REG :
                  hit_ram ? MSM_SEL_RAM :
                  hit_boot ? MSM_SEL_BOOT :
                  hit_ee ? MSM_SEL_EE :
                  hit_rom ? MSM_SEL_ROM : MSM_SEL_NONE;
endmodule
`default_nettype wire

// ==== rtl/msm_strap.sv ====
// mode strap capture at reset release
// assumes mode pins are synchronous to the clock
`timescale 1ns/1ps
`default_nettype none
module msm_strap
   import msm_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_mode_a_pin,
   input wire logic i_mode_b_pin,
   output logic o_taken,
   output logic o_mode_a,
   output logic o_mode_b
);
   logic in_rst;
   logic loaded;
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         in_rst <= 1'b1;
      end else begin
         in_rst <= 1'b0;
      end
   end
   // pins sampled only on the first edge after release
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_mode_a <= 1'b0;
         o_mode_b <= 1'b1;
      end else if (in_rst) begin
         o_mode_a <= i_mode_a_pin;
         o_mode_b <= i_mode_b_pin;
      end
   end
   // load strobe one edge after capture, so captured levels are used
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         loaded <= 1'b0;
      end else begin
         loaded <= in_rst;
      end
   end
   assign o_taken = loaded;
endmodule
`default_nettype wire

// ==== rtl/msm_top.sv ====
// mode select, priority register and memory map control
// assumes cpu supplies fetch marks and internal read indications
// Overview of operation
// - register, then RAM, then ROM priority
// - boot ROM mapped only in special modes, with boot enable
// - expanded: ROM on only with enable
// - single chip, bootstrap: ROM always on
// - small EEPROM fixed at B600
// - large EEPROM default F800, relocatable
// - window n places EEPROM at n800
// - mode pins sampled only in reset
// - mode pins decode to four modes
// - special flag inverts B, latch copies A
// - mode A pin marks instruction fetch
// - vectors FFFA normal, BFFA special
// - priority register reset values per mode
// - boot enable writable in special modes
// - special flag, latch write limits
// - visibility bit written once, mode reset
// - visibility drives internal reads out
// - visibility gates bus clock in single
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module msm_top
   import msm_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_mode_a_pin,
   input wire logic i_mode_b_pin,
   input wire logic i_rom_enable_config,
   input wire logic i_ee_big,
   input wire logic i_ee_en,
   input wire logic [3:0] i_nvm_window_select,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_fetch_first,
   input wire logic i_bus_clk,
   output logic [7:0] o_rdata,
   output logic [2:0] o_sel,
   output logic o_mode_a_pin_out,
   output logic o_mode_a_pin_oe,
   output logic o_bus_clk_pin,
   output logic o_read_visible,
   output logic [15:0] o_vector_base,
   output logic [1:0] o_mode,
   output logic o_special_mode_flag
);
   logic taken;
   logic cap_a;
   logic cap_b;
   logic boot_rom_enable;
   logic special_mode_flag;
   logic mode_a_latch;
   logic read_visibility_or_clock_off;
   logic [3:0] psel;
   logic latch_a_done;
   logic rvis_done;
   logic rom_on;
   logic live;
   msm_mode_e mode;
   msm_sel_e sel;

   msm_strap u_strap (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_mode_a_pin(i_mode_a_pin),
      .i_mode_b_pin(i_mode_b_pin),
      .o_taken(taken),
      .o_mode_a(cap_a),
      .o_mode_b(cap_b)
   );

   // pin level mode from the captured straps
   wire msm_mode_e strap_mode = cap_b ? (cap_a ? MSM_EXPANDED : MSM_SINGLE)
                                      : (cap_a ? MSM_TEST : MSM_BOOTSTRAP);
   wire wr_hit = i_wr && (i_addr == MSM_PRIO_MISC_ADDR);
   wire rd_hit = i_rd && (i_addr == MSM_PRIO_MISC_ADDR);
   wire single_like = (mode == MSM_SINGLE) || (mode == MSM_BOOTSTRAP);
   wire w_boot = i_wdata[MSM_BOOT_BIT];
   wire w_special = i_wdata[MSM_SPECIAL_BIT];
   wire w_latch_a = i_wdata[MSM_LATCH_A_BIT];
   wire reg_range = (i_addr & MSM_REG_MASK) == MSM_REG_BASE;
   wire ram_range = (i_addr & MSM_RAM_MASK) == MSM_RAM_BASE;
   wire w_rvis = i_wdata[MSM_RVIS_BIT];
   wire [7:0] reg_view = {boot_rom_enable, special_mode_flag, mode_a_latch,
                          read_visibility_or_clock_off, psel};

   // mode and control bits; loaded on the second edge after release, then software
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         mode <= MSM_SINGLE;
         boot_rom_enable <= 1'b0;
         special_mode_flag <= 1'b0;
         mode_a_latch <= 1'b0;
         read_visibility_or_clock_off <= 1'b0;
         psel <= MSM_PSEL_RST;
         latch_a_done <= 1'b0;
         rvis_done <= 1'b0;
         rom_on <= 1'b0;
      end else if (taken) begin
         mode <= strap_mode;
         boot_rom_enable <= (strap_mode == MSM_BOOTSTRAP);
         special_mode_flag <= ~cap_b;
         mode_a_latch <= cap_a;
         read_visibility_or_clock_off <= (strap_mode == MSM_TEST);
         psel <= MSM_PSEL_RST;
         rom_on <= (strap_mode == MSM_EXPANDED || strap_mode == MSM_TEST) ?
                   i_rom_enable_config : 1'b1;
      end else if (wr_hit) begin
         psel <= i_wdata[3:0];
         if (special_mode_flag) begin
            boot_rom_enable <= w_boot;
            mode_a_latch <= w_latch_a;
         end else if (!latch_a_done) begin
            mode_a_latch <= w_latch_a;
         end
         special_mode_flag <= special_mode_flag & w_special;
         latch_a_done <= 1'b1;
         if (!rvis_done) begin
            read_visibility_or_clock_off <= w_rvis;
         end
         rvis_done <= 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         live <= 1'b0;
      end else begin
         live <= 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else if (rd_hit) begin
         o_rdata <= reg_view;
      end else begin
         o_rdata <= 8'h00;
      end
   end

   msm_decode u_decode (
      .i_addr(i_addr),
      .i_boot_en(boot_rom_enable && special_mode_flag),
      .i_rom_en(rom_on),
      .i_ee_big(i_ee_big),
      .i_ee_en(i_ee_en),
      .i_window(i_nvm_window_select),
      .o_sel(sel)
   );
   assign o_sel = sel;

   // fetch marker is open drain, active low, only once running
   assign o_mode_a_pin_out = 1'b0;
   assign o_mode_a_pin_oe = live && !taken && i_fetch_first;
   assign o_read_visible = !single_like && read_visibility_or_clock_off &&
                           (sel != MSM_SEL_NONE) && i_rd;
   assign o_bus_clk_pin = (single_like && read_visibility_or_clock_off) ? 1'b0 : i_bus_clk;
   assign o_vector_base = special_mode_flag ? MSM_SPECIAL_VEC : MSM_NORMAL_VEC;
   assign o_mode = mode;
   assign o_special_mode_flag = special_mode_flag;

   a_special_no_set: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (!taken && !special_mode_flag) |=> !special_mode_flag)
      else $error("special flag set again");
   a_rvis_once: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (!taken && rvis_done) |=> $stable(read_visibility_or_clock_off))
      else $error("visibility bit written twice");
   a_boot_map: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (sel == MSM_SEL_BOOT) |-> (boot_rom_enable && special_mode_flag))
      else $error("boot rom mapped outside special");
   a_reg_first: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      ((i_addr & MSM_REG_MASK) == MSM_REG_BASE) |-> (sel == MSM_SEL_REG))
      else $error("register block lost priority");
   a_release_load: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      taken |=> (special_mode_flag == !$past(cap_b)) && (mode_a_latch == $past(cap_a)))
      else $error("mode bits wrong after release");
   a_mode_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (live && !taken) |=> $stable(mode))
      else $error("mode changed after reset");
   a_clock_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (single_like && read_visibility_or_clock_off) |-> !o_bus_clk_pin)
      else $error("bus clock not held low");
   a_vector_sel: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !special_mode_flag |-> (o_vector_base == MSM_NORMAL_VEC))
      else $error("wrong vector base");

   // load cycle, then the first running cycle
   sequence s_loaded;
      taken ##1 (live && !taken);
   endsequence

   sequence s_normal_write;
      wr_hit && !taken && !special_mode_flag;
   endsequence

   sequence s_special_write;
      wr_hit && !taken && special_mode_flag;
   endsequence

   sequence s_first_vis_write;
      wr_hit && !taken && !rvis_done;
   endsequence

   // release and load behaviour
   a_load_once: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_loaded |=> (!taken && $stable(mode)))
      else $error("mode loaded twice");

   a_mode_load: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      taken |=> (mode == $past(strap_mode)))
      else $error("mode not taken from straps");

   a_boot_reset: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      taken |=> (boot_rom_enable == ($past(strap_mode) == MSM_BOOTSTRAP)))
      else $error("boot enable reset value wrong");

   a_vis_reset: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      taken |=> (read_visibility_or_clock_off == ($past(strap_mode) == MSM_TEST)))
      else $error("visibility reset value wrong");

   a_psel_reset: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      taken |=> (psel == MSM_PSEL_RST))
      else $error("priority select reset value wrong");

   a_rom_config: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (taken && ((strap_mode == MSM_EXPANDED) || (strap_mode == MSM_TEST)))
      |=> (rom_on == $past(i_rom_enable_config)))
      else $error("rom enable not from config");

   a_rom_single: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (live && !taken && single_like) |-> rom_on)
      else $error("rom off in single chip");

   a_rom_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (live && !taken) |=> $stable(rom_on))
      else $error("rom enable changed while running");

   // write protection of the control bits
   a_latch_first: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_normal_write and !latch_a_done) |=> (mode_a_latch == $past(w_latch_a)))
      else $error("first latch write lost");

   a_latch_locked: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_normal_write and latch_a_done) |=> $stable(mode_a_latch))
      else $error("latch written twice");

   a_latch_special: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_special_write |=> (mode_a_latch == $past(w_latch_a)))
      else $error("latch write lost in special");

   a_boot_special: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_special_write |=> (boot_rom_enable == $past(w_boot)))
      else $error("boot enable write lost");

   a_boot_locked: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_normal_write |=> $stable(boot_rom_enable))
      else $error("boot enable written in normal");

   a_special_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_special_write |=> (special_mode_flag == $past(w_special)))
      else $error("special flag write lost");

   a_vis_first: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_first_vis_write |=> (read_visibility_or_clock_off == $past(w_rvis)))
      else $error("first visibility write lost");

   a_once_used: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (wr_hit && !taken) |=> (rvis_done && latch_a_done))
      else $error("once flags not used up");

   // decode priority and windows
   a_ram_second: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (ram_range && !reg_range) |-> (sel == MSM_SEL_RAM))
      else $error("ram lost priority");

   a_rom_region: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (sel == MSM_SEL_ROM) |-> (rom_on && ((i_addr & MSM_ROM_MASK) == MSM_ROM_BASE)))
      else $error("rom selected outside its range");

   a_ee_present: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (sel == MSM_SEL_EE) |-> i_ee_en)
      else $error("eeprom selected while absent");

   a_ee_small: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (sel == MSM_SEL_EE && !i_ee_big) |-> ((i_addr & MSM_EE512_MASK) == MSM_EE512_BASE))
      else $error("small eeprom outside fixed range");

   a_ee_window: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (sel == MSM_SEL_EE && i_ee_big) |-> (i_addr[15:11] == {i_nvm_window_select, 1'b1}))
      else $error("large eeprom outside window");

   // pins, visibility, vector base and read data
   a_fetch_mark: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (live && !taken && i_fetch_first) |-> (o_mode_a_pin_oe && !o_mode_a_pin_out))
      else $error("fetch marker missing");

   a_mark_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !i_fetch_first |-> !o_mode_a_pin_oe)
      else $error("fetch marker without fetch");

   a_vis_single: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      single_like |-> !o_read_visible)
      else $error("read visible in single chip");

   a_vis_off: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !read_visibility_or_clock_off |-> !o_read_visible)
      else $error("read visible while off");

   a_vis_on: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (!single_like && read_visibility_or_clock_off && i_rd && (sel == MSM_SEL_REG))
      |-> o_read_visible)
      else $error("internal read not visible");

   a_clock_pass: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (!single_like || !read_visibility_or_clock_off) |-> (o_bus_clk_pin == i_bus_clk))
      else $error("bus clock not driven out");

   a_vector_special: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      special_mode_flag |-> (o_vector_base == MSM_SPECIAL_VEC))
      else $error("special vector base wrong");

   a_read_data: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      rd_hit |=> (o_rdata == $past(reg_view)))
      else $error("register read data wrong");

   a_read_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !rd_hit |=> (o_rdata == 8'h00))
      else $error("read data without read");
endmodule
`default_nettype wire

// ==== dv/msm_board.sv ====
// strap board and bus clock source beside the mode block
// assumes the mode A pin is pulled to its strap level
`timescale 1ns/1ps
`default_nettype none
module msm_board (
   input wire logic i_ref_clk,
   input wire logic [1:0] i_strap,
   input wire logic i_oe,
   output logic o_mode_a,
   output logic o_mode_b,
   output logic o_bus_clk
);
   // straps held by the board, mode A pulled low by the marker
   assign o_mode_b = i_strap[1];
   assign o_mode_a = i_oe ? 1'b0 : i_strap[0];
   // unknown start settles to a toggle from the first edge
   always @(posedge i_ref_clk) begin
      o_bus_clk <= (o_bus_clk !== 1'b1);
   end
endmodule
`default_nettype wire

// ==== dv/msm_top_test.sv ====
// self-checking bench for the mode select and memory map block
// assumes the board model drives the straps and the bus clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
   $display("Error t=%0t got %h exp %h", $time, a, b); end end
module msm_top_test;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [1:0] strap = 2'b10;
   logic rom_cfg = 1'b0;
   logic ee_big = 1'b0;
   logic ee_en = 1'b0;
   logic [3:0] win = 4'hF;
   logic [15:0] i_addr = 16'h0000;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic fetch = 1'b0;
   wire logic mode_a, mode_b, bus_clk, oe, pin_out, bclk_pin, rvis, spec_flag;
   wire logic [7:0] rdata;
   wire logic [2:0] sel;
   wire logic [15:0] vec;
   wire logic [1:0] mode;
   int fail_count = 0;
   int check_count = 0;
   always #12.5 i_ref_clk = ~i_ref_clk;
   msm_board msm_board_inst (.i_ref_clk(i_ref_clk), .i_strap(strap), .i_oe(oe),
      .o_mode_a(mode_a), .o_mode_b(mode_b), .o_bus_clk(bus_clk));
   msm_top msm_top_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_mode_a_pin(mode_a),
      .i_mode_b_pin(mode_b), .i_rom_enable_config(rom_cfg), .i_ee_big(ee_big),
      .i_ee_en(ee_en), .i_nvm_window_select(win), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_fetch_first(fetch), .i_bus_clk(bus_clk),
      .o_rdata(rdata), .o_sel(sel), .o_mode_a_pin_out(pin_out), .o_mode_a_pin_oe(oe),
      .o_bus_clk_pin(bclk_pin), .o_read_visible(rvis), .o_vector_base(vec),
      .o_mode(mode), .o_special_mode_flag(spec_flag));
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask
   task automatic dec(input logic [15:0] a, input logic [2:0] e);
      @(posedge i_ref_clk);
      i_addr <= a;
      #1 `CHK(sel, e)
   endtask
   // visibility is looked at while the read strobe stands
   task automatic vis(input logic [15:0] a, input logic e);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      #1 `CHK(rvis, e)
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      logic [7:0] rv, w3, x;
      logic [1:0] m;
      for (int k = 0; k < 5; k++) begin
         m = (k == 4) ? 2'd1 : k[1:0];
         @(posedge i_ref_clk);
         i_rst <= 1'b1;
         strap <= {~m[1], m[0]};
         rom_cfg <= (k == 4);
         ee_en <= 1'b0;
         ee_big <= 1'b0;
         repeat (6) @(posedge i_ref_clk);
         i_rst <= 1'b0;
         repeat (3) @(posedge i_ref_clk);
         strap <= ~strap;
         rv = {m == 2'd2, m[1], m[0], m == 2'd3, 4'h6};
         #1 `CHK(mode, m)
         `CHK(spec_flag, m[1])
         `CHK(vec, m[1] ? 16'hBFFA : 16'hFFFA)
         rd(16'h103C, rv);
         dec(16'h1000, 3'd1);
         dec(16'h0000, 3'd2);
         dec(16'hC000, (!m[0] || k == 4) ? 3'd3 : 3'd0);
         dec(16'hBF00, (m == 2'd2) ? 3'd4 : 3'd0);
         if (!m[0]) `CHK(bclk_pin, bus_clk)
         vis(16'h103C, m[0] & rv[4]);
         wr(16'h103C, rv ^ 8'h10);
         wr(16'h103C, rv);
         rd(16'h103C, rv ^ 8'h10);
         vis(16'h103C, m[0] & ~rv[4]);
         if (!m[0]) `CHK(bclk_pin, 1'b0)
         w3 = (rv ^ 8'hB0) & 8'hBF;
         x = m[1] ? w3 : (rv ^ 8'h10);
         wr(16'h103C, w3);
         wr(16'h103C, x | 8'h40);
         rd(16'h103C, x);
         dec(16'hBF00, 3'd0);
         @(posedge i_ref_clk);
         fetch <= 1'b1;
         @(posedge i_ref_clk);
         @(negedge i_ref_clk) `CHK(oe, 1'b1)
         `CHK(pin_out, 1'b0)
         @(posedge i_ref_clk);
         fetch <= 1'b0;
         repeat (2) @(posedge i_ref_clk);
         @(negedge i_ref_clk) `CHK(oe, 1'b0)
         `CHK(mode, m)
         if (k == 0) begin
            rd(16'h1000, 8'h00);
            @(posedge i_ref_clk);
            ee_en <= 1'b1;
            dec(16'hB600, 3'd5);
            dec(16'hB7FF, 3'd5);
            @(posedge i_ref_clk);
            ee_big <= 1'b1;
            for (int n = 0; n < 16; n++) begin
               @(posedge i_ref_clk);
               win <= n[3:0];
               dec({n[3:0], 12'h800}, 3'd5);
            end
         end
         $display("test %0d done", k);
      end
      summarize();
   end
   // cut a hang short, far beyond the expected run
   initial begin
      #500000;
      fail_count++;
      summarize();
   end
endmodule
`default_nettype wire
